// file: rtl/agu_defines.svh
`ifndef AGU_DEFINES_SVH
`define AGU_DEFINES_SVH

// Register port byte offsets
`define AGU_OFS_WFILE_END 8'h20
`define AGU_OFS_CTRL      8'h46
`define AGU_OFS_XSTART    8'h48
`define AGU_OFS_XEND      8'h4a
`define AGU_OFS_YSTART    8'h4c
`define AGU_OFS_YEND      8'h4e

// Reset values
`define AGU_RST_CTRL      16'h00ff
`define AGU_RST_START     16'h0000
`define AGU_RST_END       16'h0001
`define AGU_RST_DEFAULT_WORKING_REGISTER      16'h0000

// Control field positions and masks
`define AGU_CTRL_XEN      15
`define AGU_CTRL_YEN      14
`define AGU_CTRL_YSEL_LSB 4
`define AGU_CTRL_XSEL_LSB 0
`define AGU_CTRL_MASK     16'hc0ff
`define AGU_SEL_OFF       4'hf

// Fixed register numbers and literal masks
`define AGU_W0            4'h0
`define AGU_MAC_X_BASE    4'h8
`define AGU_MAC_Y_BASE    4'ha
`define AGU_INTERRUPT_DISABLE_INSTRUCTION_MASK     16'h3fff
`define AGU_LIT5_MASK     16'h001f
`define AGU_WORD_MASK     16'hfffe

`endif

// file: rtl/agu_pkg.sv
package agu_pkg;

    typedef enum logic [2:0] {
        AM_FILE, AM_DIRECT, AM_IND, AM_POST, AM_PRE, AM_REG_OFS, AM_LIT_OFS
    } agu_mode_t;

    typedef enum logic [2:0] {
        MM_IND, MM_POST2, MM_POST4, MM_POST6, MM_IDX
    } agu_mac_mode_t;

    typedef struct packed {
        agu_mode_t   mode;
        logic [3:0]  ptr;
    } agu_opnd_t;

    typedef struct packed {
        logic        valid;
        agu_opnd_t   src;
        agu_opnd_t   dst;
        logic        dst_en;
        logic [3:0]  ofs;
        logic [15:0] lit;
        logic [12:0] fr;
        logic        op2_lit;
        logic        prog;
    } agu_xreq_t;

    typedef struct packed {
        logic          valid;
        logic          x_hi;
        agu_mac_mode_t x_mode;
        logic [3:0]    x_ofs;
        logic          y_hi;
        agu_mac_mode_t y_mode;
        logic [3:0]    y_ofs;
        logic          dec;
    } agu_macreq_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] ea;
        logic        prog;
    } agu_ea_t;

    typedef struct packed {
        logic        valid;
        logic        to_default_working_register;
        logic [15:0] data;
    } agu_res_t;

    typedef struct packed {
        logic        valid;
        logic [12:0] addr;
    } agu_frw_t;

    typedef struct packed {
        logic [15:0] op1;
        logic [15:0] op2;
    } agu_ops_t;

endpackage

// file: rtl/agu_circ.sv
`timescale 1ns/1ps
module agu_circ #(
    parameter int W = 16
) (
    // Candidate and pointer before the step
    input  logic [W-1:0] cand,
    input  logic [W-1:0] prev,
    // Buffer bounds
    input  logic [W-1:0] start,
    input  logic [W-1:0] stop,
    input  logic         en,
    input  logic         word,
    // Corrected address
    output logic [W-1:0] corr
);
    logic [W:0]   len;
    logic         pow2;
    logic         up;
    logic         fix_hi;
    logic         fix_lo;
    logic [W-1:0] sum;

    // Length is one wider so a full 64 KB buffer is representable
    assign len    = {1'b0, stop} - {1'b0, start} + {{W{1'b0}}, 1'b1};
    assign pow2   = (len & (len - {{W{1'b0}}, 1'b1})) == '0;
    assign up     = cand >= prev;
    // Beyond the bound, not equal to it; both bounds only for 2^n lengths
    assign fix_hi = en && (cand > stop) && (up || pow2);
    assign fix_lo = en && (cand < start) && (!up || pow2);
    assign sum    = fix_hi ? cand - len[W-1:0] :
                    fix_lo ? cand + len[W-1:0] : cand;
    assign corr   = word ? {sum[W-1:1], 1'b0} : sum;
endmodule

// file: rtl/agu_wfile.sv
`timescale 1ns/1ps
`include "agu_defines.svh"
module agu_wfile #(
    parameter int N  = 16,
    parameter int W  = 16,
    parameter int P  = 5,
    parameter int IW = 4
) (
    // Clock and reset
    input  logic                   clk,
    input  logic                   rst_b,
    // Write ports, lower index wins
    input  logic [P-1:0]           we,
    input  logic [P-1:0][IW-1:0]   widx,
    input  logic [P-1:0][W-1:0]    wdat,
    // Register contents
    output logic [N-1:0][W-1:0]    regs
);
    for (genvar i = 0; i < N; i++) begin : g_reg
        logic [W-1:0] q_r;
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                q_r <= `AGU_RST_DEFAULT_WORKING_REGISTER;
            end else begin
                for (int k = P - 1; k >= 0; k--) begin
                    if (we[k] && widx[k] == IW'(i)) begin
                        q_r <= wdat[k];
                    end
                end
            end
        end
        assign regs[i] = q_r;
    end
endmodule

// file: rtl/agu_top.sv
`timescale 1ns/1ps
`include "agu_defines.svh"
// Overview of operation
// - Separate X and Y address generators work in parallel.
// - The Y generator serves only word reads of multiply-accumulate operations.
// - Circular addressing works for data and program pointers.
// - File-register direct uses a 13-bit field, the lowest 8192 bytes.
// - File-register results go to the file register or to register zero.
// - Three-operand: first source register direct; second register or 5-bit literal.
// - Indirect uses the pointer as address; post-modify then steps the pointer.
// - Pre-modify steps the pointer by a signed constant, then uses it.
// - Register offset: address is pointer plus offset register.
// - Literal offset: address is pointer plus instruction literal.
// - Move source and destination modes share one 4-bit offset field.
// - Prefetch registers eight and nine go to X, ten and eleven to Y.
// - Multiply-accumulate indexed mode only through registers nine and eleven.
// - Multiply-accumulate: indirect, post-modify by 2, 4, 6, indexed only.
// - Branch literal is 16-bit signed; interrupt-disable count 14-bit unsigned.
// - One circular buffer in X and one in Y, simultaneously.
// - Power-of-two buffers check both bounds, allowing both directions.
// - Each buffer has 16-bit start and end bounds; length is their difference plus one.
// - A circular buffer may be up to 32K words long.
// - Y circular addresses are word aligned with bit zero clear.
// - Pointer select 15 disables circular mode; otherwise its enable bit rules.
// - Bounds trip only when exceeded, so overshooting steps are corrected.
// - Corrected address written back only for pre- and post-modify.
module agu_top (
    // Clock and reset
    input  logic                 clk,
    input  logic                 rst_b,
    // Register port
    input  logic [7:0]           addr,
    input  logic [15:0]          wdata,
    input  logic                 wr,
    input  logic                 rd,
    output logic [15:0]          rdata,
    // Requests
    input  agu_pkg::agu_xreq_t   x_req,
    input  agu_pkg::agu_macreq_t mac_req,
    input  agu_pkg::agu_res_t    res,
    input  logic [15:0]          lit_raw,
    input  logic                 lit_interrupt_disable_instruction,
    // Results
    output agu_pkg::agu_ea_t     x_rd_ea,
    output agu_pkg::agu_ea_t     x_wr_ea,
    output agu_pkg::agu_ea_t     y_rd_ea,
    output agu_pkg::agu_ops_t    ops,
    output agu_pkg::agu_frw_t    fr_wr,
    output logic [15:0]          lit_value,
    output logic                 mac_err
);
    logic [15:0][15:0]    wregs;
    logic [15:0]          ctrl_r, xs_r, xe_r, ys_r, ye_r;
    logic [15:0]          rdata_r, lit_r;
    logic [12:0]          last_fr_r;
    logic                 mac_err_r;
    agu_pkg::agu_ea_t     xr_r, xw_r, yr_r;
    agu_pkg::agu_ops_t    ops_r;
    agu_pkg::agu_frw_t    frw_r;
    logic                 mv, xgo, wgo, bad_x, bad_y;
    agu_pkg::agu_mode_t   xm, wm, ym;
    logic [3:0]           xp, xo, wp, yp, xsel, ysel;
    logic [15:0]          xl, yl, x_pv, x_ov, w_pv, y_pv, y_ov;
    logic [15:0]          x_cand, w_cand, y_cand, x_corr, w_corr, y_corr;
    logic                 x_cen, w_cen, y_cen;
    logic [4:0]           we;
    logic [4:0][3:0]      widx;
    logic [4:0][15:0]     wdat;

    function automatic logic [15:0] cand_f(agu_pkg::agu_mode_t m,
                                           logic [15:0] p, logic [15:0] o,
                                           logic [15:0] l);
        unique case (m)
            agu_pkg::AM_POST,
            agu_pkg::AM_PRE:     cand_f = p + l;
            agu_pkg::AM_REG_OFS: cand_f = p + o;
            agu_pkg::AM_LIT_OFS: cand_f = p + l;
            default:             cand_f = p;
        endcase
    endfunction

    function automatic logic [15:0] ea_f(agu_pkg::agu_mode_t m, logic [12:0] f,
                                         logic [15:0] p, logic [15:0] c);
        unique case (m)
            agu_pkg::AM_FILE:    ea_f = {3'h0, f};
            agu_pkg::AM_PRE,
            agu_pkg::AM_REG_OFS,
            agu_pkg::AM_LIT_OFS: ea_f = c;
            default:             ea_f = p;
        endcase
    endfunction

    function automatic logic mod_f(agu_pkg::agu_mode_t m);
        mod_f = m == agu_pkg::AM_PRE || m == agu_pkg::AM_POST;
    endfunction

    function automatic logic circ_ok_f(agu_pkg::agu_mode_t m);
        circ_ok_f = mod_f(m) || m == agu_pkg::AM_REG_OFS || m == agu_pkg::AM_LIT_OFS;
    endfunction

    function automatic agu_pkg::agu_mode_t mac_mode_f(agu_pkg::agu_mac_mode_t m,
                                                      logic hi);
        unique case (m)
            agu_pkg::MM_POST2,
            agu_pkg::MM_POST4,
            agu_pkg::MM_POST6: mac_mode_f = agu_pkg::AM_POST;
            agu_pkg::MM_IDX:   mac_mode_f = hi ? agu_pkg::AM_REG_OFS
                                               : agu_pkg::AM_IND;
            default:           mac_mode_f = agu_pkg::AM_IND;
        endcase
    endfunction

    function automatic logic [15:0] mac_step_f(agu_pkg::agu_mac_mode_t m, logic dec);
        logic [15:0] s;
        unique case (m)
            agu_pkg::MM_POST2: s = 16'h0002;
            agu_pkg::MM_POST4: s = 16'h0004;
            agu_pkg::MM_POST6: s = 16'h0006;
            default:           s = 16'h0000;
        endcase
        mac_step_f = dec ? 16'h0000 - s : s;
    endfunction

    // Request steering; a multiply-accumulate request owns the X read side
    assign mv    = mac_req.valid;
    assign xgo   = mv || x_req.valid;
    assign wgo   = x_req.valid && x_req.dst_en && !mv;
    assign bad_x = mac_req.x_mode == agu_pkg::MM_IDX && !mac_req.x_hi;
    assign bad_y = mac_req.y_mode == agu_pkg::MM_IDX && !mac_req.y_hi;
    assign xm    = mv ? mac_mode_f(mac_req.x_mode, mac_req.x_hi) : x_req.src.mode;
    assign xp    = mv ? (`AGU_MAC_X_BASE | {3'h0, mac_req.x_hi}) : x_req.src.ptr;
    assign xo    = mv ? mac_req.x_ofs : x_req.ofs;
    assign xl    = mv ? mac_step_f(mac_req.x_mode, mac_req.dec) : x_req.lit;
    assign wm    = x_req.dst.mode;
    assign wp    = x_req.dst.ptr;
    assign ym    = mac_mode_f(mac_req.y_mode, mac_req.y_hi);
    assign yp    = `AGU_MAC_Y_BASE | {3'h0, mac_req.y_hi};
    assign yl    = mac_step_f(mac_req.y_mode, mac_req.dec);

    assign x_pv  = wregs[xp];
    assign x_ov  = wregs[xo];
    assign w_pv  = wregs[wp];
    assign y_pv  = wregs[yp];
    assign y_ov  = wregs[mac_req.y_ofs];

    assign x_cand = cand_f(xm, x_pv, x_ov, xl);
    // Move destination reuses the single shared offset field
    assign w_cand = cand_f(wm, w_pv, x_ov, x_req.lit);
    assign y_cand = cand_f(ym, y_pv, y_ov, yl);

    // Select 15 turns circular mode off; X read and write share one buffer
    assign xsel  = ctrl_r[`AGU_CTRL_XSEL_LSB +: 4];
    assign ysel  = ctrl_r[`AGU_CTRL_YSEL_LSB +: 4];
    assign x_cen = ctrl_r[`AGU_CTRL_XEN] && xsel != `AGU_SEL_OFF
                   && xsel == xp && circ_ok_f(xm);
    assign w_cen = ctrl_r[`AGU_CTRL_XEN] && xsel != `AGU_SEL_OFF
                   && xsel == wp && circ_ok_f(wm);
    assign y_cen = ctrl_r[`AGU_CTRL_YEN] && ysel != `AGU_SEL_OFF
                   && ysel == yp && circ_ok_f(ym);

    // Program-space pointers take the same X correction as data pointers
    agu_circ #(.W(16)) u_xr (
        .cand  (x_cand),
        .prev  (x_pv),
        .start (xs_r),
        .stop  (xe_r),
        .en    (x_cen),
        .word  (1'b0),
        .corr  (x_corr)
    );

    agu_circ #(.W(16)) u_xw (
        .cand  (w_cand),
        .prev  (w_pv),
        .start (xs_r),
        .stop  (xe_r),
        .en    (w_cen),
        .word  (1'b0),
        .corr  (w_corr)
    );

    agu_circ #(.W(16)) u_yr (
        .cand  (y_cand),
        .prev  (y_pv),
        .start (ys_r),
        .stop  (ye_r),
        .en    (y_cen),
        .word  (1'b1),
        .corr  (y_corr)
    );

    // Write-back: offset modes leave the pointer alone
    assign we[0]   = wgo && mod_f(wm);
    assign widx[0] = wp;
    assign wdat[0] = w_corr;
    assign we[1]   = xgo && mod_f(xm);
    assign widx[1] = xp;
    assign wdat[1] = x_corr;
    assign we[2]   = mv && mod_f(ym);
    assign widx[2] = yp;
    assign wdat[2] = y_corr;
    assign we[3]   = res.valid && res.to_default_working_register;
    assign widx[3] = `AGU_W0;
    assign wdat[3] = res.data;
    assign we[4]   = wr && addr < `AGU_OFS_WFILE_END && !addr[0];
    assign widx[4] = addr[4:1];
    assign wdat[4] = wdata;

    agu_wfile #(.N(16), .W(16), .P(5), .IW(4)) u_wfile (
        .clk   (clk),
        .rst_b (rst_b),
        .we    (we),
        .widx  (widx),
        .wdat  (wdat),
        .regs  (wregs)
    );

    // Circular control and bounds; bit 0 of the bounds is fixed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= `AGU_RST_CTRL;
            xs_r   <= `AGU_RST_START;
            xe_r   <= `AGU_RST_END;
            ys_r   <= `AGU_RST_START;
            ye_r   <= `AGU_RST_END;
        end else if (wr) begin
            unique case (addr)
                `AGU_OFS_CTRL:   ctrl_r <= wdata & `AGU_CTRL_MASK;
                `AGU_OFS_XSTART: xs_r   <= wdata & `AGU_WORD_MASK;
                `AGU_OFS_XEND:   xe_r   <= wdata | ~`AGU_WORD_MASK;
                `AGU_OFS_YSTART: ys_r   <= wdata & `AGU_WORD_MASK;
                `AGU_OFS_YEND:   ye_r   <= wdata | ~`AGU_WORD_MASK;
                default: ;
            endcase
        end
    end

    // Read data stands one cycle only; unmapped reads return zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 16'h0000;
        end else if (!rd) begin
            rdata_r <= 16'h0000;
        end else if (addr < `AGU_OFS_WFILE_END) begin
            rdata_r <= addr[0] ? 16'h0000 : wregs[addr[4:1]];
        end else begin
            unique case (addr)
                `AGU_OFS_CTRL:   rdata_r <= ctrl_r;
                `AGU_OFS_XSTART: rdata_r <= xs_r;
                `AGU_OFS_XEND:   rdata_r <= xe_r;
                `AGU_OFS_YSTART: rdata_r <= ys_r;
                `AGU_OFS_YEND:   rdata_r <= ye_r;
                default:         rdata_r <= 16'h0000;
            endcase
        end
    end

    // Effective addresses, one register stage per generator
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            xr_r <= '0;
            xw_r <= '0;
            yr_r <= '0;
        end else begin
            xr_r.valid <= xgo && xm != agu_pkg::AM_DIRECT;
            xr_r.ea    <= ea_f(xm, x_req.fr, x_pv, x_corr);
            xr_r.prog  <= !mv && x_req.prog;
            xw_r.valid <= wgo && wm != agu_pkg::AM_DIRECT;
            xw_r.ea    <= ea_f(wm, x_req.fr, w_pv, w_corr);
            xw_r.prog  <= x_req.prog;
            yr_r.valid <= mv;
            yr_r.ea    <= ea_f(ym, 13'h0000, y_pv, y_corr) & `AGU_WORD_MASK;
            yr_r.prog  <= 1'b0;
        end
    end

    // Operands of three-operand and file-register instructions
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ops_r     <= '0;
            last_fr_r <= 13'h0000;
            frw_r     <= '0;
        end else begin
            if (x_req.valid && !mv) begin
                ops_r.op1 <= x_ov;
                ops_r.op2 <= x_req.op2_lit ? (x_req.lit & `AGU_LIT5_MASK) : x_pv;
            end
            if (x_req.valid && !mv && x_req.src.mode == agu_pkg::AM_FILE) begin
                last_fr_r <= x_req.fr;
            end
            frw_r.valid <= res.valid && !res.to_default_working_register;
            frw_r.addr  <= last_fr_r;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lit_r     <= 16'h0000;
            mac_err_r <= 1'b0;
        end else begin
            lit_r     <= lit_interrupt_disable_instruction ? (lit_raw & `AGU_INTERRUPT_DISABLE_INSTRUCTION_MASK) : lit_raw;
            mac_err_r <= mv && (bad_x || bad_y);
        end
    end

    assign rdata     = rdata_r;
    assign x_rd_ea   = xr_r;
    assign x_wr_ea   = xw_r;
    assign y_rd_ea   = yr_r;
    assign ops       = ops_r;
    assign fr_wr     = frw_r;
    assign lit_value = lit_r;
    assign mac_err   = mac_err_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_FILE_EA: assert property (
        x_req.valid && !mv && x_req.src.mode == agu_pkg::AM_FILE
        |=> x_rd_ea.valid && x_rd_ea.ea == {3'h0, $past(x_req.fr)})
        else $error("file direct address wrong");
    AST_Y_MAC_ONLY: assert property (
        !mv |=> !y_rd_ea.valid)
        else $error("Y address without multiply-accumulate");
    AST_Y_WORD: assert property (
        y_rd_ea.valid |-> !y_rd_ea.ea[0] && !wregs[$past(yp)][0] || !$past(we[2]))
        else $error("Y address not word aligned");
    AST_POST: assert property (
        x_req.valid && !mv && !x_req.dst_en && x_req.src.mode == agu_pkg::AM_POST
        && !x_cen |=> x_rd_ea.ea == $past(x_pv)
        && wregs[$past(xp)] == $past(x_pv + x_req.lit))
        else $error("post-modify wrong");
    AST_PRE: assert property (
        x_req.valid && !mv && x_req.src.mode == agu_pkg::AM_PRE && !x_cen
        |=> x_rd_ea.ea == $past(x_pv + x_req.lit))
        else $error("pre-modify address wrong");
    AST_REG_OFS: assert property (
        x_req.valid && !mv && x_req.src.mode == agu_pkg::AM_REG_OFS && !x_cen
        |=> x_rd_ea.ea == $past(x_pv + x_ov))
        else $error("register offset address wrong");
    AST_NO_WB_OFS: assert property (
        x_req.valid && !mv && !x_req.dst_en && !wr && !res.valid
        && x_req.src.mode == agu_pkg::AM_LIT_OFS
        |=> wregs[$past(xp)] == $past(x_pv))
        else $error("offset mode changed pointer");
    AST_WRAP_UP: assert property (
        x_req.valid && !mv && x_req.src.mode == agu_pkg::AM_PRE && x_cen
        && x_pv <= xe_r && x_cand > xe_r && x_cand >= x_pv
        |=> x_rd_ea.ea == $past(xs_r + (x_cand - xe_r - 16'h0001)))
        else $error("circular wrap wrong");
    AST_CIRC_OFF: assert property (
        xsel == `AGU_SEL_OFF |-> !x_cen && !w_cen)
        else $error("circular active with select off");
    AST_MAC_STEP: assert property (
        mv && mac_req.x_mode == agu_pkg::MM_POST4 && !mac_req.dec && !x_cen
        |=> wregs[`AGU_MAC_X_BASE | {3'h0, $past(mac_req.x_hi)}]
            == $past(x_pv) + 16'h0004)
        else $error("prefetch step wrong");
    AST_MAC_IDX: assert property (
        mv && bad_x |=> mac_err ##1 !mac_err || $past(mv))
        else $error("indexed prefetch error missed");
    AST_RES_W0: assert property (
        res.valid && res.to_default_working_register |=> wregs[0] == $past(res.data) || $past(we[1] || we[0]))
        else $error("result not in register zero");

    COV_X_WRAP: cover property (x_req.valid && x_cen && x_corr != x_cand);
    COV_Y_WRAP: cover property (mv && y_cen && y_corr != (y_cand & `AGU_WORD_MASK));
    COV_MOVE:   cover property (wgo && x_req.valid);
    COV_MAC:    cover property (mv ##1 y_rd_ea.valid);
endmodule

// file: tb/agu_top_bench.sv
`timescale 1ns/1ps
module agu_top_bench;
    logic                 clk = 0;
    logic                 rst_b = 0;
    logic [7:0]           addr = '0;
    logic [15:0]          wdata = '0;
    logic                 wr = 0;
    logic                 rd = 0;
    logic [15:0]          rdata;
    agu_pkg::agu_xreq_t   x_req = '0;
    agu_pkg::agu_macreq_t mac_req = '0;
    agu_pkg::agu_res_t    res = '0;
    logic [15:0]          lit_raw = '0;
    logic                 lit_interrupt_disable_instruction = 0;
    agu_pkg::agu_ea_t     x_rd_ea;
    agu_pkg::agu_ea_t     x_wr_ea;
    agu_pkg::agu_ea_t     y_rd_ea;
    agu_pkg::agu_ops_t    ops;
    agu_pkg::agu_frw_t    fr_wr;
    logic                 mac_err;
    logic [15:0]          lit_value;
    logic [15:0]          qr[$], qx[$], qy[$], ql[$], qw[$], qo[$], qf[$], qe[$];
    int                   err_count = 0;
    int                   total_checks = 0;
    int                   cyc = 0;
    logic                 rd_d = 0, lg = 0, lg_d = 0;
    logic [31:0]          seed = 32'hd014;
    logic [15:0]          r, v, a, b;
    agu_pkg::agu_macreq_t m;
    agu_pkg::agu_xreq_t   t;

    agu_top dut_u (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .x_req(x_req), .mac_req(mac_req), .res(res), .lit_raw(lit_raw),
        .lit_interrupt_disable_instruction(lit_interrupt_disable_instruction), .x_rd_ea(x_rd_ea), .x_wr_ea(x_wr_ea), .y_rd_ea(y_rd_ea),
        .ops(ops), .fr_wr(fr_wr), .lit_value(lit_value), .mac_err(mac_err));

    always #2 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [15:0] pop(ref logic [15:0] q[$]);
        // An unexpected result meets an unknown and so always mismatches
        return q.size() ? q.pop_front() : 16'hxxxx;
    endfunction

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic summarize;
        if (qr.size() + qx.size() + qy.size() + ql.size() + qw.size() + qo.size()
            + qf.size() + qe.size() != 0) err_count++;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic default_working_register(input logic [7:0] ad, input logic [15:0] d);
        @(posedge clk);
        wr <= 1; addr <= ad; wdata <= d;
        @(posedge clk);
        wr <= 0;
    endtask

    task automatic rreg(input logic [7:0] ad, input logic [15:0] e);
        @(posedge clk);
        rd <= 1; addr <= ad; qr.push_back(e);
        @(posedge clk);
        rd <= 0;
    endtask

    task automatic xop(input agu_pkg::agu_mode_t md, input logic [3:0] p, input logic [3:0] o,
                       input logic [15:0] l, input logic [15:0] e);
        agu_pkg::agu_xreq_t t;
        t = '0; t.valid = 1; t.src.mode = md; t.src.ptr = p; t.ofs = o; t.lit = l;
        t.fr = l[12:0];
        @(posedge clk);
        x_req <= t; qx.push_back(e);
        @(posedge clk);
        x_req <= '0;
    endtask

    // Outputs are compared half a cycle after the edge so they have settled
    always @(posedge clk) begin
        rd_d <= rd;
        lg_d <= lg;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            summarize;
        end
    end
    always @(negedge clk) if (rst_b) begin
        if (rd_d) chk("rdata", pop(qr), rdata);
        if (x_rd_ea.valid !== 1'b0) chk("x_rd_ea", pop(qx), x_rd_ea.ea);
        if (x_wr_ea.valid !== 1'b0) begin
            chk("x_wr_ea", pop(qw), x_wr_ea.ea);
            chk("op1", pop(qo), ops.op1);
            chk("op2", pop(qo), ops.op2);
        end
        if (y_rd_ea.valid !== 1'b0) chk("y_rd_ea", pop(qy), y_rd_ea.ea);
        if (fr_wr.valid !== 1'b0) chk("fr_wr", pop(qf), {3'h0, fr_wr.addr});
        if (mac_err !== 1'b0) chk("mac_err", pop(qe), {15'h0, mac_err});
        if (lg_d) chk("lit_value", pop(ql), lit_value);
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1;
        rreg(8'h46, 16'h00ff);
        rreg(8'h48, 16'h0000);
        rreg(8'h4a, 16'h0001);
        rreg(8'h4c, 16'h0000);
        rreg(8'h4e, 16'h0001);
        rreg(8'h60, 16'h0000);
        $display("reset values done");
        seed = xs(seed);
        r = seed[15:0] & 16'h3ffe;
        v = seed[31:16] & 16'h00fe;
        default_working_register(8'h06, r);
        default_working_register(8'h08, v);
        xop(agu_pkg::AM_IND, 4'h3, 4'h0, 16'h0000, r);
        xop(agu_pkg::AM_POST, 4'h3, 4'h0, 16'h0002, r);
        xop(agu_pkg::AM_PRE, 4'h3, 4'h0, 16'hfffc, r - 16'h2);
        xop(agu_pkg::AM_REG_OFS, 4'h3, 4'h4, 16'h0000, r - 16'h2 + v);
        xop(agu_pkg::AM_LIT_OFS, 4'h3, 4'h0, 16'h0010, r + 16'he);
        rreg(8'h06, r - 16'h2);
        xop(agu_pkg::AM_FILE, 4'h0, 4'h0, 16'h1abc, 16'h1abc);
        @(posedge clk);
        res <= '{valid: 1'b1, to_default_working_register: 1'b1, data: v};
        @(posedge clk);
        res <= '{valid: 1'b1, to_default_working_register: 1'b0, data: v};
        qf.push_back(16'h1abc);
        @(posedge clk);
        res <= '0;
        rreg(8'h00, v);
        $display("linear modes done");
        default_working_register(8'h48, 16'h1000);
        default_working_register(8'h4a, 16'h100f);
        default_working_register(8'h46, 16'h80f5);
        default_working_register(8'h0a, 16'h100e);
        xop(agu_pkg::AM_LIT_OFS, 4'h5, 4'h0, 16'h0004, 16'h1002);
        xop(agu_pkg::AM_POST, 4'h5, 4'h0, 16'h0006, 16'h100e);
        rreg(8'h0a, 16'h1004);
        xop(agu_pkg::AM_PRE, 4'h5, 4'h0, 16'hfffa, 16'h100e);
        xop(agu_pkg::AM_PRE, 4'h5, 4'h0, 16'h0004, 16'h1002);
        default_working_register(8'h46, 16'h80ff);
        xop(agu_pkg::AM_POST, 4'h5, 4'h0, 16'h0002, 16'h1002);
        rreg(8'h0a, 16'h1004);
        $display("circular done");
        seed = xs(seed);
        a = seed[15:0] & 16'h3ffe;
        b = seed[31:16] & 16'h3ffe;
        default_working_register(8'h10, a);
        default_working_register(8'h14, b);
        m = '0; m.valid = 1; m.x_mode = agu_pkg::MM_POST4; m.y_mode = agu_pkg::MM_POST2;
        @(posedge clk);
        mac_req <= m; qx.push_back(a); qy.push_back(b);
        @(posedge clk);
        mac_req <= '0;
        rreg(8'h10, a + 16'h4);
        rreg(8'h14, b + 16'h2);
        m.x_mode = agu_pkg::MM_IDX;
        m.y_mode = agu_pkg::MM_IND;
        @(posedge clk);
        mac_req <= m;
        qx.push_back(a + 16'h4);
        qy.push_back(b + 16'h2);
        qe.push_back(16'h0001);
        @(posedge clk);
        mac_req <= '0;
        $display("mac prefetch done");
        t = '0;
        t.valid = 1;
        t.src.mode = agu_pkg::AM_IND;
        t.src.ptr = 4'h3;
        t.dst_en = 1;
        t.dst.mode = agu_pkg::AM_REG_OFS;
        t.dst.ptr = 4'h5;
        t.ofs = 4'h4;
        t.op2_lit = 1;
        t.lit = 16'hffe3;
        @(posedge clk);
        x_req <= t;
        qx.push_back(r - 16'h2);
        qw.push_back(16'h1004 + v);
        qo.push_back(v);
        qo.push_back(16'h0003);
        @(posedge clk);
        x_req <= '0;
        $display("move done");
        for (int i = 0; i < 2; i++) begin
            seed = xs(seed);
            @(posedge clk);
            lit_raw <= seed[15:0]; lit_interrupt_disable_instruction <= i[0]; lg <= 1;
            ql.push_back(i ? seed[15:0] & 16'h3fff : seed[15:0]);
            @(posedge clk);
            lg <= 0;
        end
        repeat (3) @(posedge clk);
        $display("literals done");
        summarize;
    end
endmodule
